// File: verilog/timer16_regs.svh
// timer16_regs.svh: register offsets, field positions, reset values and
// fixed counts of the 16-bit waveform timer.
// assumes a 32-bit APB slave with byte addresses in the low 8 bits.
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define TMR_OFS_CTRL   8'h00
`define TMR_OFS_COUNT  8'h04
`define TMR_OFS_CMPA   8'h08
`define TMR_OFS_CMPB   8'h0C
`define TMR_OFS_CAPT   8'h10
`define TMR_OFS_FLAGS  8'h14
`define TMR_OFS_STAT   8'h18

// ------------------------------------------------------------------
// control field positions
// ------------------------------------------------------------------
`define TMR_CTRL_MODE  3:0
`define TMR_CTRL_ACTA  5:4
`define TMR_CTRL_ACTB  7:6
`define TMR_CTRL_CSEL  10:8
`define TMR_CTRL_DIRA  11
`define TMR_CTRL_DIRB  12

// flag bit positions
`define TMR_FLG_OVF    0
`define TMR_FLG_CMPA   1
`define TMR_FLG_CMPB   2
`define TMR_FLG_CAPT   3

// ------------------------------------------------------------------
// reset values and fixed counts
// ------------------------------------------------------------------
`define TMR_RST_WORD   16'h0000
`define TMR_MAX        16'hFFFF
`define TMR_TOP8       16'h00FF
`define TMR_TOP9       16'h01FF
`define TMR_TOP10      16'h03FF
`define TMR_PRE8       10'h007
`define TMR_PRE64      10'h03F
`define TMR_PRE256     10'h0FF
`define TMR_PRE1024    10'h3FF

`endif

// File: verilog/timer16_pkg.sv
// timer16_pkg.sv: types of the 16-bit waveform timer.
// assumes timer16_regs.svh supplies all numeric constants except the prescaler encodings.
package timer16_pkg;

    // ------------------------------------------------------------------
    // prescaler selections
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CLK_STOP = 3'h0,
        CLK_DIV1 = 3'h1,
        CLK_DIV8 = 3'h2,
        CLK_DIV64 = 3'h3,
        CLK_DIV256 = 3'h4,
        CLK_DIV1024 = 3'h5
    } clk_sel_t;

    // ------------------------------------------------------------------
    // whole state of the timer
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cmpA;
        logic [15:0] cmpB;
        logic [15:0] bufA;
        logic [15:0] bufB;
        logic [15:0] capt;
        logic        down;
        logic        wvA;
        logic        wvB;
        logic        block;
        logic [3:0]  flags;
        logic [3:0]  mode;
        logic [1:0]  actA;
        logic [1:0]  actB;
        logic [2:0]  clkSel;
        logic        dirA;
        logic        dirB;
        logic [9:0]  pre;
        logic [31:0] rdata;
    } tmr_state_t;

endpackage

// File: verilog/timer16_wave.sv
// timer16_wave.sv: counter, compare, flag and waveform logic of a 16-bit
// timer with clear-on-match, fast and phase correct PWM, on APB.
// assumes one 125 MHz clock, a synchronous active-low reset and an APB
// master that holds each request until pready.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "timer16_regs.svh"

// Contract
// - clear_on_match modes 4 and 12 clear count on compare A / capture TOP.
// - unbuffered TOP below count makes counter wrap through 0xFFFF first.
// - action 1 in clear_on_match toggles wave_out_a on each A match.
// - wave_out_a reaches the pin only while pin_direction_a is 1.
// - clear_on_match sets overflow when count rolls from MAX to zero.
// - fast PWM modes 5,6,7,14,15 count up and restart at BOTTOM.
// - fast PWM TOP is 0xFF, 0x1FF, 0x3FF, capture or A; clear after TOP.
// - fast PWM non-inverting sets on match, clears at TOP; inverted opposite.
// - in PWM modes action 2 is non-inverted, action 3 inverted.
// - fast PWM sets overflow at TOP plus the flag of the TOP register.
// - with fixed TOP, compare writes lose bits above the resolution.
// - fast PWM compare A writes go to a buffer, loaded at TOP.
// - capture TOP is unbuffered; low value makes counter wrap first.
// - compare zero gives a one-cycle spike; compare TOP gives steady level.
// - mode 15 with action 1 toggles wave_out_a, giving 50% duty.
// - phase correct modes 1,2,3,10,11 count up to TOP and back down.
// - phase correct clears on up match, sets on down match; inverted opposite.
// - phase correct sets overflow when the counter reaches BOTTOM.
// - phase correct loads buffers at TOP and sets the TOP register flag.
// - any compare match sets the matching compare flag.
// - timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// - reset clears the wave_out state to zero.
// - action 0 leaves wave_out unchanged on a match, in every mode.
// - a count write suppresses compare matches in the next timer tick.
module timer16_wave
    import timer16_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // compare pins
    output logic             waveOutAPin,
    output logic             waveOutAOe,
    output logic             waveOutBPin,
    output logic             waveOutBOe
);

    // ------------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------------
    tmr_state_t s;
    tmr_state_t n;

    logic        ctcM;
    logic        fastM;
    logic        pcM;
    logic        fixedM;
    logic        captTop;
    logic        cmpATop;
    logic [15:0] topV;
    logic        tick;
    logic        topHit;
    logic        matchA;
    logic        matchB;
    logic        upEff;
    logic        wrEn;
    logic        mapped;
    logic [31:0] rdMux;
    logic [15:0] wrMask;

    // mode classes; encodings outside them keep the counter idle
    assign ctcM    = (s.mode == 4'h4) || (s.mode == 4'hC);
    assign fastM   = (s.mode == 4'h5) || (s.mode == 4'h6)
                  || (s.mode == 4'h7) || (s.mode == 4'hE)
                  || (s.mode == 4'hF);
    assign pcM     = (s.mode == 4'h1) || (s.mode == 4'h2)
                  || (s.mode == 4'h3) || (s.mode == 4'hA)
                  || (s.mode == 4'hB);
    assign fixedM  = (fastM || pcM) && (s.mode[3] == 1'b0);
    assign captTop = (s.mode == 4'hC) || (s.mode == 4'hE)
                  || (s.mode == 4'hA);
    assign cmpATop = (s.mode == 4'h4) || (s.mode == 4'hF)
                  || (s.mode == 4'hB);

    // top selection from fixed values or the chosen register
    always_comb
    begin
        case (s.mode[1:0])
            2'h1:    topV = `TMR_TOP8;
            2'h2:    topV = `TMR_TOP9;
            2'h3:    topV = `TMR_TOP10;
            default: topV = `TMR_MAX;
        endcase
        if (captTop)
            topV = s.capt;
        else if (cmpATop)
            topV = s.cmpA;
    end

    // prescaler tick; the free counter keeps every divider phase-aligned
    always_comb
    begin
        case (s.clkSel)
            CLK_DIV1:    tick = 1'b1;
            CLK_DIV8:    tick = ((s.pre & `TMR_PRE8) == `TMR_PRE8);
            CLK_DIV64:   tick = ((s.pre & `TMR_PRE64) == `TMR_PRE64);
            CLK_DIV256:  tick = ((s.pre & `TMR_PRE256) == `TMR_PRE256);
            CLK_DIV1024: tick = (s.pre == `TMR_PRE1024);
            default:     tick = 1'b0;
        endcase
    end

    // equality compares; a count write masks them for one tick
    assign topHit = (s.cnt == topV) && !s.block;
    assign matchA = tick && (s.cnt == s.cmpA) && !s.block;
    assign matchB = tick && (s.cnt == s.cmpB) && !s.block;
    // bottom counts as rising, top as falling, so the extremes stay steady
    assign upEff  = s.down ? (s.cnt == `TMR_RST_WORD) : !topHit;

    // masks compare writes to the resolution of a fixed top
    assign wrMask = fixedM ? topV : `TMR_MAX;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign wrEn    = psel && penable && pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = s.rdata;

    always_comb
    begin
        mapped = 1'b1;
        rdMux  = 32'h0000_0000;
        case (paddr)
            `TMR_OFS_CTRL:
            begin
                rdMux[`TMR_CTRL_MODE] = s.mode;
                rdMux[`TMR_CTRL_ACTA] = s.actA;
                rdMux[`TMR_CTRL_ACTB] = s.actB;
                rdMux[`TMR_CTRL_CSEL] = s.clkSel;
                rdMux[`TMR_CTRL_DIRA] = s.dirA;
                rdMux[`TMR_CTRL_DIRB] = s.dirB;
            end
            `TMR_OFS_COUNT: rdMux[15:0] = s.cnt;
            `TMR_OFS_CMPA:  rdMux[15:0] = s.bufA;  // software sees the buffer
            `TMR_OFS_CMPB:  rdMux[15:0] = s.bufB;
            `TMR_OFS_CAPT:  rdMux[15:0] = s.capt;
            `TMR_OFS_FLAGS: rdMux[3:0]  = s.flags;
            `TMR_OFS_STAT:  rdMux[2:0]  = {s.down, s.wvB, s.wvA};
            default:        mapped      = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // next wave level for one channel
    // ------------------------------------------------------------------
    function automatic logic waveNext(
        input logic [1:0] act,
        input logic       w,
        input logic       hit,
        input logic       isA
    );
        logic r;
        r = w;
        if (act == 2'h0)
            r = w;
        else if (ctcM && hit)
            r = (act == 2'h1) ? !w : act[0];
        else if (fastM && act == 2'h1)
            r = (hit && isA && s.mode == 4'hF) ? !w : w;
        else if (fastM)
            // top clears for action 2 and sets for action 3, a match in the same tick overrides it
            r = hit ? !act[0] : (topHit ? act[0] : w);
        else if (pcM && hit && act == 2'h1)
            r = (isA && s.mode == 4'hB) ? !w : w;
        else if (pcM && hit)
            r = upEff ? act[0] : !act[0];
        return r;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [3:0] setF;
        logic [3:0] clrF;
        setF  = 4'h0;
        clrF  = 4'h0;
        n     = s;
        n.pre = s.pre + 10'h001;
        // read data is caught in the setup cycle so it is stable in access
        if (psel && !penable)
        begin
            n.rdata = rdMux;
        end
        if (tick)
        begin
            n.block = 1'b0;
            if (ctcM)
            begin
                n.cnt = topHit ? `TMR_RST_WORD : s.cnt + 16'h0001;
                setF[`TMR_FLG_OVF]  = (s.cnt == `TMR_MAX);
                setF[`TMR_FLG_CAPT] = topHit && captTop;
            end
            else if (fastM)
            begin
                if (topHit)
                begin
                    n.cnt  = `TMR_RST_WORD;
                    n.cmpA = s.bufA;
                    n.cmpB = s.bufB;
                    setF[`TMR_FLG_OVF]  = 1'b1;
                    setF[`TMR_FLG_CAPT] = captTop;
                    setF[`TMR_FLG_CMPA] = cmpATop;
                end
                else
                begin
                    n.cnt = s.cnt + 16'h0001;
                end
            end
            else if (pcM)
            begin
                if (!s.down && topHit)
                begin
                    n.down = 1'b1;
                    n.cnt  = s.cnt - 16'h0001;
                    n.cmpA = s.bufA;
                    n.cmpB = s.bufB;
                    setF[`TMR_FLG_CAPT] = captTop;
                    setF[`TMR_FLG_CMPA] = cmpATop;
                end
                else if (s.down && s.cnt == `TMR_RST_WORD)
                begin
                    n.down = 1'b0;
                    n.cnt  = s.cnt + 16'h0001;
                    setF[`TMR_FLG_OVF] = 1'b1;
                end
                else
                begin
                    n.cnt = s.down ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
                end
            end
            n.wvA = waveNext(s.actA, s.wvA, matchA, 1'b1);
            n.wvB = waveNext(s.actB, s.wvB, matchB, 1'b0);
        end
        setF[`TMR_FLG_CMPA] = setF[`TMR_FLG_CMPA] | matchA;
        setF[`TMR_FLG_CMPB] = matchB;
        // register writes override the timer, but a flag set wins over its clear; buffers only in pwm modes
        if (wrEn)
        begin
            case (paddr)
                `TMR_OFS_CTRL:
                begin
                    n.mode   = pwdata[`TMR_CTRL_MODE];
                    n.actA   = pwdata[`TMR_CTRL_ACTA];
                    n.actB   = pwdata[`TMR_CTRL_ACTB];
                    n.clkSel = pwdata[`TMR_CTRL_CSEL];
                    n.dirA   = pwdata[`TMR_CTRL_DIRA];
                    n.dirB   = pwdata[`TMR_CTRL_DIRB];
                end
                `TMR_OFS_COUNT:
                begin
                    n.cnt   = pwdata[15:0];
                    n.block = 1'b1;
                end
                `TMR_OFS_CMPA:
                begin
                    n.bufA = pwdata[15:0] & wrMask;
                    if (!(fastM || pcM))
                    begin
                        n.cmpA = pwdata[15:0] & wrMask;
                    end
                end
                `TMR_OFS_CMPB:
                begin
                    n.bufB = pwdata[15:0] & wrMask;
                    if (!(fastM || pcM))
                    begin
                        n.cmpB = pwdata[15:0] & wrMask;
                    end
                end
                `TMR_OFS_CAPT:  n.capt = pwdata[15:0];
                `TMR_OFS_FLAGS: clrF   = pwdata[3:0];
                default:        n.capt = s.capt;
            endcase
        end
        // a flag raised in its clearing cycle survives the clear
        n.flags = (s.flags & ~clrF) | setF;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    // pin override: the wave shows only while the direction is output
    assign waveOutAPin = s.dirA & s.wvA;
    assign waveOutAOe  = s.dirA;
    assign waveOutBPin = s.dirB & s.wvB;
    assign waveOutBOe  = s.dirB;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_ctcClear;
        @(posedge sys_clk) disable iff (!rstn)
        (tick && ctcM && topHit && !wrEn) |=> (s.cnt == 16'h0000);
    endproperty
    a_ctcClear: assert property (p_ctcClear)
        else $error("counter not cleared on top match");

    property p_ctcOvf;
        @(posedge sys_clk) disable iff (!rstn)
        (tick && ctcM && s.cnt == 16'hFFFF) |=> s.flags[0];
    endproperty
    a_ctcOvf: assert property (p_ctcOvf)
        else $error("overflow flag missed at wrap");

    property p_toggle;
        @(posedge sys_clk) disable iff (!rstn)
        (ctcM && s.actA == 2'h1 && matchA) |=> (s.wvA != $past(s.wvA));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("wave a did not toggle on match");

    property p_pin;
        @(posedge sys_clk) disable iff (!rstn)
        (!s.dirA |-> !waveOutAPin) and (s.dirA |-> waveOutAPin == s.wvA);
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin shows wave while direction is input");

    property p_fastLoad;
        @(posedge sys_clk) disable iff (!rstn)
        (tick && fastM && topHit && !wrEn)
            |=> (s.cmpA == $past(s.bufA)) && s.flags[0] && s.cnt == 16'h0;
    endproperty
    a_fastLoad: assert property (p_fastLoad)
        else $error("buffer load, clear and overflow not together");

    property p_pcBottom;
        @(posedge sys_clk) disable iff (!rstn)
        (tick && pcM && s.down && s.cnt == 16'h0 && !wrEn)
            |=> s.flags[0] && !s.down;
    endproperty
    a_pcBottom: assert property (p_pcBottom)
        else $error("phase correct bottom missed overflow");

    property p_cmpFlag;
        @(posedge sys_clk) disable iff (!rstn)
        matchB |=> s.flags[2];
    endproperty
    a_cmpFlag: assert property (p_cmpFlag)
        else $error("compare b flag not set on match");

    property p_blockOne;
        @(posedge sys_clk) disable iff (!rstn)
        (s.block && tick) |-> !matchA && !matchB;
    endproperty
    a_blockOne: assert property (p_blockOne)
        else $error("match not suppressed after count write");

    property p_div8;
        @(posedge sys_clk) disable iff (!rstn)
        (s.clkSel == 3'h2 && tick) ##1 (s.clkSel == 3'h2) [*7]
            |-> !$past(tick);
    endproperty
    a_div8: assert property (p_div8)
        else $error("divide by eight tick too early");

endmodule

// File: test/tb_timer16_wave.sv
// tb_timer16_wave.sv: self-checking bench for the 16-bit waveform timer.
// assumes the zero-wait apb slave and register map of timer16_regs.svh.
`timescale 1ns/1ps
`include "timer16_regs.svh"
module tb_timer16_wave;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        waveOutAPin;
    logic        waveOutAOe;
    logic        waveOutBPin;
    logic        waveOutBOe;
    logic [31:0] rdv;
    logic        errv;
    logic        v;
    int          mismatches      = 0;
    int          samples_checked = 0;
    int          n;
    int          divs[4] = '{8, 64, 256, 1024};
    logic [31:0] masks[3] = '{32'h0000_0034, 32'h0000_0034, 32'h0000_0234};

    timer16_wave uut (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .waveOutAPin(waveOutAPin),
        .waveOutAOe(waveOutAOe), .waveOutBPin(waveOutBPin),
        .waveOutBOe(waveOutBOe)
    );

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    function automatic logic [31:0] ctl(input int md, act, cs, dir);
        return {20'h0_0000, dir[0], cs[2:0], 2'b00, act[1:0], md[3:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for pready; only the watchdog ends a hung access
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // stop the tick and park the counter at zero before a new mode
    task automatic park(input int cmp);
        apb(1, `TMR_OFS_CTRL, ctl(4, 0, 0, 1));
        apb(1, `TMR_OFS_CMPA, cmp);
        apb(1, `TMR_OFS_COUNT, 0);
    endtask

    task automatic run_len(output int len);
        logic lv;
        lv = waveOutAPin;
        len = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            len++;
        end
        while (waveOutAPin === lv && len < 70000);
    endtask

    // settle, sync on a pin edge, then time one high and one low run
    task automatic seg(input int hi, input int lo);
        int a;
        int b;
        repeat (40) @(posedge sys_clk);
        #1;
        run_len(a);
        v = waveOutAPin;
        run_len(a);
        run_len(b);
        check("high run", v ? a : b, hi);
        check("low run", v ? b : a, lo);
    endtask

    task automatic hold(input int cyc, input logic exp);
        logic bad;
        bad = 1'b0;
        repeat (cyc)
        begin
            @(posedge sys_clk);
            #1;
            if (waveOutAPin !== exp)
                bad = 1'b1;
        end
        check("steady pin", {31'h0, bad}, 32'h0000_0000);
    endtask

    // flags are cleared, given time to set again, then read
    task automatic flags(input logic [31:0] m);
        apb(1, `TMR_OFS_FLAGS, 32'h0000_000F);
        repeat (30) @(posedge sys_clk);
        apb(0, `TMR_OFS_FLAGS, 0);
        check("flags", rdv & m, m);
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d samples_checked %0d",
                 mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(0, `TMR_OFS_STAT, 0);
        check("stat", rdv, 32'h0000_0000);
        check("pin", {31'h0, waveOutAPin}, 32'h0000_0000);
        check("pin b", {30'h0, waveOutBOe, waveOutBPin},
              32'h0000_0000);
        check("ready", {31'h0, pready}, 32'h0000_0001);
        apb(0, 8'h1C, 0);
        check("unmapped", {31'h0, errv}, 32'h0000_0001);
        apb(1, `TMR_OFS_CMPA, 2);
        apb(1, `TMR_OFS_CTRL, ctl(4, 1, 1, 1));
        seg(3, 3);
        flags(32'h0000_0002);
        apb(0, `TMR_OFS_FLAGS, 0);
        check("no ovf", rdv & 1, 32'h0000_0000);
        apb(1, `TMR_OFS_CTRL, ctl(4, 1, 1, 0));
        hold(20, 1'b0);
        check("oe", {31'h0, waveOutAOe}, 32'h0000_0000);
        apb(1, `TMR_OFS_CAPT, 4);
        apb(1, `TMR_OFS_CTRL, ctl(12, 1, 1, 1));
        seg(5, 5);
        flags(32'h0000_0008);
        // compare 1 toggles every second tick, so a run is 2 divisions
        park(1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `TMR_OFS_CTRL, ctl(4, 1, i + 2, 1));
            seg(2 * divs[i], 2 * divs[i]);
        end
        park(32'h0000_0080);
        apb(1, `TMR_OFS_CTRL, ctl(5, 2, 1, 1));
        seg(127, 129);
        for (int i = 0; i < 3; i++)
        begin
            apb(1, `TMR_OFS_CTRL, ctl(5 + i, 2, 0, 1));
            apb(1, `TMR_OFS_CMPA, 32'h0000_1234);
            apb(0, `TMR_OFS_CMPA, 0);
            check("masked cmp", rdv, masks[i]);
        end
        park(3);
        apb(1, `TMR_OFS_CAPT, 9);
        apb(1, `TMR_OFS_CTRL, ctl(14, 2, 1, 1));
        seg(6, 4);
        apb(1, `TMR_OFS_CTRL, ctl(14, 3, 1, 1));
        seg(4, 6);
        flags(32'h0000_000B);
        apb(1, `TMR_OFS_CTRL, ctl(14, 2, 1, 1));
        apb(1, `TMR_OFS_CMPA, 0);
        seg(9, 1);
        apb(1, `TMR_OFS_CMPA, 9);
        repeat (20) @(posedge sys_clk);
        hold(30, 1'b1);
        park(4);
        apb(1, `TMR_OFS_CTRL, ctl(15, 1, 1, 1));
        seg(5, 5);
        apb(1, `TMR_OFS_CMPA, 9);
        seg(10, 10);
        park(3);
        apb(1, `TMR_OFS_CTRL, ctl(10, 2, 1, 1));
        seg(6, 12);
        flags(32'h0000_0009);
        apb(1, `TMR_OFS_CTRL, ctl(10, 3, 1, 1));
        seg(12, 6);
        park(1);
        apb(1, `TMR_OFS_CTRL, ctl(4, 0, 1, 1));
        #1;
        hold(30, waveOutAPin);
        // count written equal to compare: that match is lost, so wrap
        park(5);
        apb(1, `TMR_OFS_COUNT, 5);
        apb(1, `TMR_OFS_CTRL, ctl(4, 1, 1, 1));
        #1;
        hold(40, waveOutAPin);
        apb(1, `TMR_OFS_FLAGS, 32'h0000_000F);
        run_len(n);
        check("wrap", {31'h0, n > 60000}, 32'h0000_0001);
        apb(0, `TMR_OFS_FLAGS, 0);
        check("ovf", rdv & 1, 32'h0000_0001);
        report_and_stop();
    end

    // watchdog: normal run is about 75000 cycles
    initial
    begin
        repeat (95000) @(posedge sys_clk);
        mismatches++;
        report_and_stop();
    end
endmodule
